// File: rtl/cwba_cfg.svh
`ifndef CWBA_CFG_SVH
`define CWBA_CFG_SVH

// register indices; the byte address on the bus is four times the index
`define CWBA_IDX_CTRL        16'h3000
`define CWBA_IDX_BASE0_LOW   16'h3002
`define CWBA_IDX_BASE0_HIGH  16'h3004
`define CWBA_IDX_BASE1_LOW   16'h3006
`define CWBA_IDX_BASE1_HIGH  16'h3008
`define CWBA_IDX_STATUS      16'h3020

// field positions
`define CWBA_CTRL_ENABLE_BIT 0
`define CWBA_CTRL_MODE_BIT   12
`define CWBA_HIGH_MSB        9
`define CWBA_STAT_ACTIVE_BIT 0
`define CWBA_STAT_BUSY_BIT   1
`define CWBA_STAT_PEND_BIT   2

// reset values
`define CWBA_RST_REG16       16'h0000
`define CWBA_RST_HIGH10      10'h000
`define CWBA_RST_ADDR        26'h000_0000
`define CWBA_RST_DATA        32'h0000_0000

// step between two aligned 32-bit words, in bytes
`define CWBA_WORD_STEP       26'h000_0004

`endif

// File: rtl/cwba_pkg.sv
package cwba_pkg;

  // one aligned 32-bit write toward the frame store
  typedef struct packed {
    logic [25:0] addr;
    logic [31:0] data;
  } cwba_mem_req_t;

  // one converter output word
  typedef struct packed {
    logic [31:0] data;
  } cwba_word_t;

  // placement sequencer
  typedef enum logic [0:0] {
    CWBA_IDLE,
    CWBA_FRAME
  } cwba_state_t;

endpackage

// File: rtl/cwba_top.sv
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ns
`include "cwba_cfg.svh"

module cwba_top (
  // clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  // wishbone classic slave
  input  wire logic                   cyc_i,
  input  wire logic                   stb_i,
  input  wire logic                   we_i,
  input  wire logic [17:0]            adr_i,
  input  wire logic [3:0]             sel_i,
  input  wire logic [31:0]            dat_i,
  output logic      [31:0]            dat_o,
  output logic                        ack_o,
  // converter output stream
  input  wire logic                   frame_start_i,
  input  wire logic                   frame_done_i,
  input  wire logic                   word_valid_i,
  input  wire cwba_pkg::cwba_word_t   word_i,
  output logic                        word_ready_o,
  // frame-store write port
  output logic                        mem_valid_o,
  output cwba_pkg::cwba_mem_req_t     mem_req_o,
  input  wire logic                   mem_ack_i
);
  import cwba_pkg::*;

  // register file
  logic [15:0] base0_low_q;
  logic [9:0]  base0_high_q;
  logic [15:0] base1_low_q;
  logic [9:0]  base1_high_q;
  logic        enable_q;
  logic        buffer_mode_select_q;
  // placement state
  cwba_state_t state_q;
  logic        buf_sel_q;
  logic        enable_dly_q;
  logic [25:0] addr_q;
  logic        mem_valid_d;
  logic        accept;
  logic        bus_req;
  logic        bus_wr;
  logic [15:0] idx;
  logic [25:0] base_sel;

  // joins a high and low register pair into one start address
  function automatic logic [25:0] join_base(input logic [9:0] hi, input logic [15:0] lo);
    join_base = {hi, lo};
  endfunction

  // merges the two low byte lanes of a write into a 16-bit register
  function automatic logic [15:0] lane16(input logic [15:0] old, input logic [31:0] wd,
                                         input logic [3:0] sel);
    lane16 = {sel[1] ? wd[15:8] : old[15:8], sel[0] ? wd[7:0] : old[7:0]};
  endfunction

  // bus decode: word index is the address above the byte offset
  assign idx     = adr_i[17:2];
  assign bus_req = cyc_i && stb_i && !ack_o;
  assign bus_wr  = bus_req && we_i;

  // ack one cycle after the request, dropped in the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= bus_req;
    end
  end

  // base registers; upper bits above bit 9 are never stored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      base0_low_q  <= `CWBA_RST_REG16;
      base0_high_q <= `CWBA_RST_HIGH10;
      base1_low_q  <= `CWBA_RST_REG16;
      base1_high_q <= `CWBA_RST_HIGH10;
    end else if (bus_wr) begin
      unique case (idx)
        `CWBA_IDX_BASE0_LOW:  base0_low_q <= lane16(base0_low_q, dat_i, sel_i);
        `CWBA_IDX_BASE0_HIGH: begin
          if (sel_i[0]) begin
            base0_high_q[7:0] <= dat_i[7:0];
          end
          if (sel_i[1]) begin
            base0_high_q[9:8] <= dat_i[9:8];
          end
        end
        `CWBA_IDX_BASE1_LOW:  base1_low_q <= lane16(base1_low_q, dat_i, sel_i);
        `CWBA_IDX_BASE1_HIGH: begin
          if (sel_i[0]) begin
            base1_high_q[7:0] <= dat_i[7:0];
          end
          if (sel_i[1]) begin
            base1_high_q[9:8] <= dat_i[9:8];
          end
        end
        default: ;
      endcase
    end
  end

  // control register: enable and buffer mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enable_q             <= 1'b0;
      buffer_mode_select_q <= 1'b0;
    end else if (bus_wr && idx == `CWBA_IDX_CTRL) begin
      if (sel_i[0]) begin
        enable_q <= dat_i[`CWBA_CTRL_ENABLE_BIT];
      end
      if (sel_i[1]) begin
        buffer_mode_select_q <= dat_i[`CWBA_CTRL_MODE_BIT];
      end
    end
  end

  // read mux, registered with the ack; unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= `CWBA_RST_DATA;
    end else if (bus_req && !we_i) begin
      unique case (idx)
        `CWBA_IDX_CTRL:       dat_o <= {19'h0_0000, buffer_mode_select_q, 11'h000, enable_q};
        `CWBA_IDX_BASE0_LOW:  dat_o <= {16'h0000, base0_low_q};
        `CWBA_IDX_BASE0_HIGH: dat_o <= {22'h00_0000, base0_high_q};
        `CWBA_IDX_BASE1_LOW:  dat_o <= {16'h0000, base1_low_q};
        `CWBA_IDX_BASE1_HIGH: dat_o <= {22'h00_0000, base1_high_q};
        `CWBA_IDX_STATUS:     dat_o <= {29'h0000_0000, mem_valid_o,
                                        state_q == CWBA_FRAME, buf_sel_q};
        default:              dat_o <= `CWBA_RST_DATA;
      endcase
    end else begin
      dat_o <= `CWBA_RST_DATA;
    end
  end

  // base chosen for the next frame; the second base is consulted only in double mode
  always_comb begin
    base_sel = join_base(base0_high_q, base0_low_q);
    if (buffer_mode_select_q && buf_sel_q) begin
      base_sel = join_base(base1_high_q, base1_low_q);
    end
  end

  // buffer toggle: the first buffer after every enable and in single mode, flips per finished frame in double mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enable_dly_q <= 1'b0;
      buf_sel_q    <= 1'b0;
    end else begin
      enable_dly_q <= enable_q;
      if (enable_q && !enable_dly_q) begin
        buf_sel_q <= 1'b0;
      end else if (!buffer_mode_select_q) begin
        buf_sel_q <= 1'b0;
      end else if (frame_done_i && state_q == CWBA_FRAME) begin
        buf_sel_q <= !buf_sel_q;
      end
    end
  end

  // a word is taken only while enabled, inside a frame and with the hold slot free
  assign accept = word_valid_i && word_ready_o;

  // frame sequencer and write address; low two bits are forced to zero
  // so a careless base still lands on a word boundary
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= CWBA_IDLE;
      addr_q  <= `CWBA_RST_ADDR;
    end else if (!enable_q) begin
      state_q <= CWBA_IDLE;
    end else begin
      unique case (state_q)
        CWBA_IDLE: begin
          if (frame_start_i) begin
            state_q <= CWBA_FRAME;
            addr_q  <= {base_sel[25:2], 2'b00};
          end
        end
        CWBA_FRAME: begin
          if (frame_done_i) begin
            state_q <= CWBA_IDLE;
          end else if (accept) begin
            addr_q <= addr_q + `CWBA_WORD_STEP;
          end
        end
      endcase
    end
  end

  // single hold slot toward the frame store; ready mirrors its freedom
  always_comb begin
    mem_valid_d = mem_valid_o;
    if (mem_valid_o && mem_ack_i) begin
      mem_valid_d = 1'b0;
    end
    if (accept) begin
      mem_valid_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_valid_o  <= 1'b0;
      word_ready_o <= 1'b0;
      mem_req_o    <= '0;
    end else begin
      mem_valid_o  <= mem_valid_d;
      // ready one cycle late costs a bubble but keeps the output a flop
      word_ready_o <= !mem_valid_d && enable_q && state_q == CWBA_FRAME && !frame_done_i
                      && !(accept && addr_q + `CWBA_WORD_STEP == `CWBA_RST_ADDR);
      if (accept) begin
        mem_req_o.addr <= addr_q;
        mem_req_o.data <= word_i.data;
      end
    end
  end

  // ---- checks ----
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_bus_write(logic [15:0] i);
    bus_wr && idx == i;
  endsequence

  sequence s_frame_open;
    state_q == CWBA_IDLE && enable_q && frame_start_i;
  endsequence

  a_base0_low_store: assert property (
    s_bus_write(`CWBA_IDX_BASE0_LOW) ##0 sel_i[1:0] == 2'b11 |=> base0_low_q == $past(dat_i[15:0]))
    else $error("first base low word not stored");

  a_base1_high_store: assert property (
    s_bus_write(`CWBA_IDX_BASE1_HIGH) ##0 sel_i[1:0] == 2'b11
    |=> base1_high_q == $past(dat_i[9:0]))
    else $error("second base high bits not stored");

  a_single_uses_first: assert property (
    s_frame_open and !buffer_mode_select_q
    |=> addr_q == {base0_high_q, base0_low_q[15:2], 2'b00})
    else $error("single mode frame did not start at first base");

  a_double_second: assert property (
    s_frame_open and buffer_mode_select_q && buf_sel_q
    |=> addr_q == {base1_high_q, base1_low_q[15:2], 2'b00})
    else $error("second buffer frame did not start at second base");

  a_single_no_second: assert property (
    !buffer_mode_select_q ##1 !buffer_mode_select_q |-> !buf_sel_q)
    else $error("second buffer selected in single mode");

  a_word_aligned: assert property (
    mem_valid_o |-> mem_req_o.addr[1:0] == 2'b00)
    else $error("unaligned frame-store write");

  a_addr_step: assert property (
    state_q == CWBA_FRAME && accept && !frame_done_i && enable_q
    |=> addr_q == $past(addr_q) + `CWBA_WORD_STEP ##1 mem_valid_o[*1])
    else $error("write address did not step by one word");

  a_hold_until_ack: assert property (
    mem_valid_o && !mem_ack_i |=> mem_valid_o && $stable(mem_req_o))
    else $error("frame-store request dropped before ack");

  a_alternate_frames: assert property (
    buffer_mode_select_q && frame_done_i && state_q == CWBA_FRAME && enable_q && enable_dly_q
    |=> buf_sel_q != $past(buf_sel_q))
    else $error("double mode did not switch buffer after frame");

  a_enable_first_buf: assert property (
    enable_q && !enable_dly_q |=> !buf_sel_q)
    else $error("enable did not restart at first buffer");

  a_high_read_zero: assert property (
    bus_req && !we_i && idx == `CWBA_IDX_BASE0_HIGH |=> ack_o && dat_o[31:10] == 22'h00_0000)
    else $error("upper base register reserved bits read nonzero");

  a_reset_zero: assert property (
    $fell(rst_i) |-> base0_low_q == 16'h0000 && base1_low_q == 16'h0000
    && base0_high_q == 10'h000 && base1_high_q == 10'h000)
    else $error("base registers not zero after reset");

  // one request taken by the slave at this edge
  sequence s_bus_take;
    bus_req;
  endsequence

  // acknowledge stands for exactly one cycle, so no request is taken twice
  sequence s_ack_pulse;
    ack_o ##1 !ack_o;
  endsequence

  a_ack_one_cycle: assert property (
    s_bus_take |=> s_ack_pulse)
    else $error("bus acknowledge not a single-cycle pulse");

  a_read_idle_zero: assert property (
    !ack_o |-> dat_o == 32'h0000_0000)
    else $error("read data not zero outside acknowledge");

  a_base0_high_store: assert property (
    s_bus_write(`CWBA_IDX_BASE0_HIGH) ##0 sel_i[1:0] == 2'b11
    |=> base0_high_q == $past(dat_i[9:0]))
    else $error("first base high bits not stored");

  a_base1_low_store: assert property (
    s_bus_write(`CWBA_IDX_BASE1_LOW) ##0 sel_i[1:0] == 2'b11
    |=> base1_low_q == $past(dat_i[15:0]))
    else $error("second base low word not stored");

  a_double_first: assert property (
    s_frame_open ##0 buffer_mode_select_q && !buf_sel_q
    |=> addr_q == {base0_high_q, base0_low_q[15:2], 2'b00})
    else $error("first buffer frame did not start at first base");

  a_single_base_pick: assert property (
    !buffer_mode_select_q |-> base_sel == {base0_high_q, base0_low_q})
    else $error("second base consulted in single mode");

  a_ready_slot_free: assert property (
    word_ready_o |-> !mem_valid_o)
    else $error("word offered ready while hold slot full");

  a_take_to_store: assert property (
    accept |=> mem_valid_o && mem_req_o.addr == $past(addr_q)
    && mem_req_o.data == $past(word_i.data))
    else $error("taken word not presented to frame store");

endmodule

// File: sim/cwba_mem_model.sv
`timescale 1ns/1ns
// frame store stand-in: accepts each write request after a short wait
module cwba_mem_model (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // frame-store write port
  input  wire logic mem_valid_i,
  input  wire logic slow_i,
  output logic      mem_ack_o
);
  logic [2:0] wait_q;
  // slow mode stalls up to seven cycles, so the request must stand meanwhile
  always_ff @(posedge clk_i) begin
    if (rst_i || !mem_valid_i || mem_ack_o) begin
      mem_ack_o <= 1'b0;
      wait_q    <= slow_i ? 3'($urandom_range(7)) : 3'h0;
    end else if (wait_q == 3'h0) begin
      mem_ack_o <= 1'b1;
    end else begin
      wait_q <= wait_q - 3'h1;
    end
  end
endmodule

// File: sim/tb.sv
`timescale 1ns/1ns
`include "cwba_cfg.svh"
module tb;
  import cwba_pkg::*;
  logic          clk_i = 1'b0;
  logic          rst_i = 1'b1;
  logic          cyc_i = 1'b0;
  logic          stb_i = 1'b0;
  logic          we_i = 1'b0;
  logic [17:0]   adr_i = 18'h0_0000;
  logic [31:0]   dat_i = 32'h0000_0000;
  logic [31:0]   dat_o;
  logic          ack_o;
  logic          frame_start_i = 1'b0;
  logic          frame_done_i = 1'b0;
  logic          word_valid_i = 1'b0;
  cwba_word_t    word_i = '0;
  logic          word_ready_o;
  logic          mem_valid_o;
  cwba_mem_req_t mem_req_o;
  logic          mem_ack_i;
  logic          slow = 1'b0;
  logic [3:0]    sel = 4'h3;
  logic [31:0]   rd_q[$];
  cwba_mem_req_t wr_q[$];
  logic [25:0]   b0;
  logic [25:0]   b1;
  int            error_cnt = 0;
  int            n_tests = 0;

  always #5 clk_i = ~clk_i;

  cwba_top DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .frame_start_i(frame_start_i), .frame_done_i(frame_done_i), .word_valid_i(word_valid_i),
    .word_i(word_i), .word_ready_o(word_ready_o), .mem_valid_o(mem_valid_o),
    .mem_req_o(mem_req_o), .mem_ack_i(mem_ack_i));

  cwba_mem_model mem (.clk_i(clk_i), .rst_i(rst_i), .mem_valid_i(mem_valid_o),
    .slow_i(slow), .mem_ack_o(mem_ack_i));

  task automatic final_report();
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(string what, logic [63:0] exp, logic [63:0] got);
    n_tests++;
    if (exp !== got) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // a wait that ran out ends the run as a failure
  task automatic guard(int i);
    if (i >= 200) begin
      error_cnt++;
      final_report();
    end
  endtask

  // classic single cycle; a read notes its expected data for the monitor
  task automatic wb(logic we, logic [15:0] idx, logic [15:0] wd, logic [15:0] exp);
    int i;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= we;
    adr_i <= {idx, 2'b00};
    dat_i <= {16'h0000, wd};
    if (!we) rd_q.push_back({16'h0000, exp});
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (ack_o !== 1'b1 && i < 200);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    guard(i);
  endtask

  // one frame of n words; valid stays up across words, data is a fresh random value per word
  task automatic frame(logic [25:0] base, int n);
    int          i;
    logic [31:0] d;
    @(posedge clk_i);
    frame_start_i <= 1'b1;
    @(posedge clk_i);
    frame_start_i <= 1'b0;
    word_valid_i  <= 1'b1;
    for (int k = 0; k < n; k++) begin
      d = $urandom();
      word_i.data <= d;
      wr_q.push_back({base + 26'(4 * k), d});
      i = 0;
      do begin
        @(posedge clk_i);
        i++;
      end while (word_ready_o !== 1'b1 && i < 200);
      guard(i);
    end
    word_valid_i <= 1'b0;
    @(posedge clk_i);
    frame_done_i <= 1'b1;
    @(posedge clk_i);
    frame_done_i <= 1'b0;
    i = 0;
    while ((mem_valid_o !== 1'b0 || wr_q.size() != 0) && i < 200) begin
      @(posedge clk_i);
      i++;
    end
    guard(i);
  endtask

  // monitor: oldest note is compared whenever a result shows
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0 && rd_q.size() != 0) begin
      check("read data", rd_q.pop_front(), dat_o);
    end
    if (mem_valid_o === 1'b1 && mem_ack_i === 1'b1) begin
      if (wr_q.size() == 0) check("extra write", 64'hffff_ffff_ffff_ffff, mem_req_o);
      else check("frame write", wr_q.pop_front(), mem_req_o);
    end
  end

  initial begin
    void'($urandom(32'h078a92a8));
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int r = 0; r < 4; r++) wb(1'b0, 16'h3002 + 16'(2 * r), 16'h0000, 16'h0000);
    for (int r = 0; r < 2; r++) begin
      wb(1'b1, 16'h3004 + 16'(4 * r), 16'hffff, 16'h0000);
      wb(1'b0, 16'h3004 + 16'(4 * r), 16'h0000, 16'h03ff);
    end
    // low lane only: bits 9-8 keep their old value
    sel <= 4'h1;
    wb(1'b1, `CWBA_IDX_BASE0_HIGH, 16'h0000, 16'h0000);
    sel <= 4'h3;
    wb(1'b0, `CWBA_IDX_BASE0_HIGH, 16'h0000, 16'h0300);
    wb(1'b1, 16'h300a, 16'hffff, 16'h0000);
    wb(1'b0, 16'h300a, 16'h0000, 16'h0000);
    // bases keep bits 1-0 clear and stay clear of the top of memory
    b0 = 26'($urandom() & 32'h00ff_fffc);
    b1 = 26'($urandom() & 32'h00ff_fffc);
    wb(1'b1, `CWBA_IDX_BASE0_LOW, b0[15:0], 16'h0000);
    wb(1'b1, `CWBA_IDX_BASE0_HIGH, 16'(b0[25:16]), 16'h0000);
    wb(1'b1, `CWBA_IDX_BASE1_LOW, b1[15:0], 16'h0000);
    wb(1'b1, `CWBA_IDX_BASE1_HIGH, 16'(b1[25:16]), 16'h0000);
    wb(1'b0, `CWBA_IDX_BASE0_LOW, 16'h0000, b0[15:0]);
    wb(1'b0, `CWBA_IDX_BASE0_HIGH, 16'h0000, 16'(b0[25:16]));
    wb(1'b0, `CWBA_IDX_BASE1_LOW, 16'h0000, b1[15:0]);
    wb(1'b0, `CWBA_IDX_BASE1_HIGH, 16'h0000, 16'(b1[25:16]));
    // single buffer: every frame at the first base, second base ignored
    wb(1'b1, `CWBA_IDX_CTRL, 16'h0001, 16'h0000);
    frame(b0, 3);
    wb(1'b1, `CWBA_IDX_BASE1_LOW, 16'h0040, 16'h0000);
    b1[15:0] = 16'h0040;
    slow <= 1'b1;
    frame(b0, 4);
    // double buffer after a fresh enable: first, second, first
    wb(1'b1, `CWBA_IDX_CTRL, 16'h0000, 16'h0000);
    wb(1'b1, `CWBA_IDX_CTRL, 16'h1001, 16'h0000);
    frame(b0, 3);
    wb(1'b0, `CWBA_IDX_CTRL, 16'h0000, 16'h1001);
    wb(1'b0, `CWBA_IDX_STATUS, 16'h0000, 16'h0001);
    frame(b1, 3);
    slow <= 1'b0;
    frame(b0, 2);
    final_report();
  end
endmodule
